// ---- nibble_alu_flag_logic.sv ----
// Flag logic around a nibble ALU, reached over an APB slave port.
// Assumes pclk at 50 MHz, presetn asynchronous active low,
// and in_port as an asynchronous 4-bit input pin group.
//
// What this block does
// - ALU works on 4-bit operands, returns result, carry out, zero.
// - Add and reverse subtract with carry use and store carry_flag.
// - Compare stores ALU carry out, meaning no borrow, in carry_flag.
// - Rotates move old carry in and the shifted-out bit to carry.
// - Test carry true copies carry to branch flag, then sets carry.
// - Test carry inverted copies inverted carry, then clears carry.
// - Zero flag loads ALU zero on operate, rotate, input, load.
// - Branch is taken only while branch_condition_flag is one.
// - Branch flag rests at one so branches are unconditional.
// - Reset sets branch flag, leaves carry, zero, general alone.
// - General flag is set, cleared or tested by instructions only.
`default_nettype none
`timescale 1ns/100ps

module nibble_alu_flag_logic
    import nibble_alu_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [nibble_alu_pkg::ADDR_W-1:0] paddr,
    input wire logic [nibble_alu_pkg::DATA_W-1:0] pwdata,
    output logic [nibble_alu_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] in_port,
    output logic branch_take
);

    import nibble_alu_pkg::*;

    typedef struct packed {
        ctl_state_t state;
        logic [3:0] cnt;
        logic [3:0] acc;
        logic [3:0] operand;
        opcode_t opcode;
        logic [3:0] result;
        logic taken;
        logic take_pulse;
        logic ack;
        logic err;
        logic [DATA_W-1:0] rdata;
        logic [3:0] in_meta;
        logic [3:0] in_sync;
    } state_t;

    state_t st_reg;
    state_t st_next;

    flags_t flags;
    flags_t flags_next;
    alu_out_t alu_o;
    alu_fn_t alu_fn;
    logic [3:0] alu_b;
    logic alu_cin;
    logic commit;
    logic access;
    logic [DATA_W-1:0] read_word;
    logic read_err;

    ////////////////////////////////////////////////////////////////////
    // Datapath pieces

    nibble_alu u_alu (
        .fn(alu_fn),
        .a(st_reg.acc),
        .b(alu_b),
        .cin(alu_cin),
        .alu_o(alu_o)
    );

    flag_bank u_flags (
        .pclk(pclk),
        .presetn(presetn),
        .commit(commit),
        .flags_next(flags_next),
        .flags(flags)
    );

    assign access = psel && penable;
    // Flags change only on the last execute cycle; the accumulator also changes on an APB write
    assign commit = (st_reg.state == ST_EXEC) && (st_reg.cnt == 4'h0);

    assign prdata = st_reg.rdata;
    assign pready = st_reg.ack;
    assign pslverr = st_reg.ack && st_reg.err;
    assign branch_take = st_reg.take_pulse;

    ////////////////////////////////////////////////////////////////////
    // Instruction to ALU function

    always_comb begin
        alu_fn = FN_PASS_B;
        alu_b = st_reg.operand;
        alu_cin = 1'b0;
        unique case (st_reg.opcode)
            OP_ADD_WITH_CARRY: begin
                alu_fn = FN_ADD;
                alu_cin = flags.carry_flag;
            end
            OP_REVERSE_SUBTRACT_WITH_CARRY: begin
                alu_fn = FN_RSUB;
                alu_cin = flags.carry_flag;
            end
            OP_COMPARE_REVERSE: begin
                // Plain compare: no incoming borrow
                alu_fn = FN_RSUB;
                alu_cin = 1'b1;
            end
            OP_ROTATE_LEFT_CARRY: begin
                alu_fn = FN_ROL;
                alu_cin = flags.carry_flag;
            end
            OP_ROTATE_RIGHT_CARRY: begin
                alu_fn = FN_ROR;
                alu_cin = flags.carry_flag;
            end
            OP_ADD: alu_fn = FN_ADD;
            OP_AND: alu_fn = FN_AND;
            OP_INPUT: alu_b = st_reg.in_sync;
            OP_NOP, OP_TEST_CARRY_TRUE, OP_TEST_CARRY_INVERTED,
            OP_LOAD_ACC, OP_SET_GENERAL, OP_CLEAR_GENERAL,
            OP_TEST_GENERAL, OP_BRANCH: alu_fn = FN_PASS_B;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Flag update per instruction; anything not named holds

    always_comb begin
        flags_next = flags;
        unique case (st_reg.opcode)
            OP_ADD_WITH_CARRY, OP_REVERSE_SUBTRACT_WITH_CARRY: begin
                flags_next.carry_flag = alu_o.carry_out;
                flags_next.zero_flag = alu_o.zero_out;
            end
            OP_COMPARE_REVERSE: begin
                flags_next.carry_flag = alu_o.carry_out;
                flags_next.zero_flag = alu_o.zero_out;
            end
            OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY: begin
                flags_next.carry_flag = alu_o.carry_out;
                flags_next.zero_flag = alu_o.zero_out;
            end
            OP_TEST_CARRY_TRUE: begin
                flags_next.branch_condition_flag = flags.carry_flag;
                flags_next.carry_flag = 1'b1;
            end
            OP_TEST_CARRY_INVERTED: begin
                flags_next.branch_condition_flag = ~flags.carry_flag;
                flags_next.carry_flag = 1'b0;
            end
            OP_ADD, OP_AND, OP_LOAD_ACC, OP_INPUT:
                flags_next.zero_flag = alu_o.zero_out;
            OP_SET_GENERAL: flags_next.general_flag = 1'b1;
            OP_CLEAR_GENERAL: flags_next.general_flag = 1'b0;
            OP_TEST_GENERAL:
                flags_next.branch_condition_flag = flags.general_flag;
            OP_NOP, OP_BRANCH: flags_next = flags;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Register read mux

    always_comb begin
        read_word = '0;
        read_err = 1'b0;
        unique case (paddr)
            ACC_OFFSET: read_word[3:0] = st_reg.acc;
            OPERAND_OFFSET: read_word[3:0] = st_reg.operand;
            INSTR_OFFSET: begin
                read_word[3:0] = st_reg.opcode;
                read_word[INSTR_BUSY_BIT] = (st_reg.state == ST_EXEC);
            end
            FLAGS_OFFSET: read_word[3:0] = flags;
            STATUS_OFFSET: read_word[STATUS_TAKEN_BIT] = st_reg.taken;
            RESULT_OFFSET: read_word[3:0] = st_reg.result;
            default: read_err = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Bus handshake and instruction sequencing

    always_comb begin
        st_next = st_reg;
        st_next.in_meta = in_port;
        st_next.in_sync = st_reg.in_meta;
        st_next.take_pulse = 1'b0;
        // Answer one cycle after the access phase starts, never while
        // an instruction runs: the bus stalls instead of racing it.
        if (access && !st_reg.ack && st_reg.state == ST_IDLE) begin
            st_next.ack = 1'b1;
            st_next.err = read_err;
            st_next.rdata = pwrite ? '0 : read_word;
        end
        if (access && st_reg.ack) begin
            st_next.ack = 1'b0;
            st_next.err = 1'b0;
            if (pwrite && !st_reg.err) begin
                unique case (paddr)
                    ACC_OFFSET: st_next.acc = pwdata[3:0];
                    OPERAND_OFFSET: st_next.operand = pwdata[3:0];
                    INSTR_OFFSET: begin
                        st_next.opcode = opcode_t'(pwdata[3:0]);
                        st_next.state = ST_EXEC;
                        st_next.cnt = EXEC_LAST;
                    end
                    default: st_next.ack = 1'b0;
                endcase
            end
        end
        unique case (st_reg.state)
            ST_IDLE: st_next.cnt = st_next.cnt;
            ST_EXEC: begin
                if (st_reg.cnt != 4'h0) begin
                    st_next.cnt = st_reg.cnt - 4'h1;
                end else begin
                    st_next.state = ST_IDLE;
                    unique case (st_reg.opcode)
                        OP_ADD_WITH_CARRY, OP_REVERSE_SUBTRACT_WITH_CARRY,
                        OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY,
                        OP_ADD, OP_AND, OP_LOAD_ACC, OP_INPUT: begin
                            st_next.acc = alu_o.result;
                            st_next.result = alu_o.result;
                        end
                        OP_COMPARE_REVERSE:
                            // Compare keeps the accumulator
                            st_next.result = alu_o.result;
                        OP_BRANCH: begin
                            st_next.taken = flags.branch_condition_flag;
                            st_next.take_pulse = flags.branch_condition_flag;
                        end
                        OP_NOP, OP_TEST_CARRY_TRUE, OP_TEST_CARRY_INVERTED,
                        OP_SET_GENERAL, OP_CLEAR_GENERAL,
                        OP_TEST_GENERAL: st_next.result = st_reg.result;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '{
                state: ST_IDLE,
                cnt: 4'h0,
                acc: ACC_RESET,
                operand: OPERAND_RESET,
                opcode: OP_NOP,
                result: 4'h0,
                taken: 1'b0,
                take_pulse: 1'b0,
                ack: 1'b0,
                err: 1'b0,
                rdata: '0,
                in_meta: 4'h0,
                in_sync: 4'h0
            };
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic is_exec;
    assign is_exec = (st_reg.state == ST_EXEC);

    a_sf_after_reset: assert property (
        $rose(presetn) |-> flags.branch_condition_flag
    ) else $error("branch flag not one after reset");

    a_carry_feeds_alu: assert property (
        (commit && st_reg.opcode == OP_ADD_WITH_CARRY)
        |-> alu_cin == flags.carry_flag
        ##1 flags.carry_flag == $past(alu_o.carry_out)
    ) else $error("add with carry mishandles carry");

    a_compare_keeps_acc: assert property (
        (commit && st_reg.opcode == OP_COMPARE_REVERSE)
        |=> st_reg.acc == $past(st_reg.acc)
        && flags.carry_flag == ($past(st_reg.operand) >= $past(st_reg.acc))
    ) else $error("compare result wrong");

    a_rotate_left_path: assert property (
        (commit && st_reg.opcode == OP_ROTATE_LEFT_CARRY)
        |=> st_reg.acc[3:1] == $past(st_reg.acc[2:0])
        && st_reg.acc[0] == $past(flags.carry_flag)
        && flags.carry_flag == $past(st_reg.acc[3])
    ) else $error("rotate left through carry wrong");

    a_test_true_flags: assert property (
        (commit && st_reg.opcode == OP_TEST_CARRY_TRUE)
        |=> flags.branch_condition_flag == $past(flags.carry_flag)
        && flags.carry_flag
    ) else $error("test carry true wrong");

    a_test_inv_flags: assert property (
        (commit && st_reg.opcode == OP_TEST_CARRY_INVERTED)
        |=> flags.branch_condition_flag != $past(flags.carry_flag)
        && !flags.carry_flag
    ) else $error("test carry inverted wrong");

    a_zero_from_load: assert property (
        (commit && st_reg.opcode == OP_LOAD_ACC)
        |=> flags.zero_flag == ($past(st_reg.operand) == 4'h0)
    ) else $error("zero flag not loaded");

    a_branch_on_flag: assert property (
        (commit && st_reg.opcode == OP_BRANCH)
        |=> branch_take == $past(flags.branch_condition_flag)
    ) else $error("branch decision wrong");

    a_general_hold: assert property (
        !commit |=> $stable(flags.general_flag)
    ) else $error("general flag changed outside commit");

    a_exec_length: assert property (
        $rose(is_exec) |-> is_exec [*8] ##1 !is_exec
    ) else $error("instruction length not eight cycles");

    c_add_carry: cover property (
        commit && st_reg.opcode == OP_ADD_WITH_CARRY && alu_o.carry_out
    );
    c_branch_taken: cover property (branch_take);
    c_branch_skipped: cover property (
        commit && st_reg.opcode == OP_BRANCH && !flags.branch_condition_flag
    );
    c_bus_error: cover property (pready && pslverr);

endmodule : nibble_alu_flag_logic

`default_nettype wire

// ---- nibble_alu_pkg.sv ----
// Constants and types shared by the nibble ALU flag block.
// Assumes a single pclk domain and an APB slave front end.
`default_nettype none

package nibble_alu_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Byte addresses of the APB registers
    localparam logic [7:0] ACC_OFFSET = 8'h00;
    localparam logic [7:0] OPERAND_OFFSET = 8'h04;
    localparam logic [7:0] INSTR_OFFSET = 8'h08;
    localparam logic [7:0] FLAGS_OFFSET = 8'h0C;
    localparam logic [7:0] STATUS_OFFSET = 8'h10;
    localparam logic [7:0] RESULT_OFFSET = 8'h14;

    // Field positions
    localparam int INSTR_BUSY_BIT = 4;
    localparam int STATUS_TAKEN_BIT = 0;

    // Reset values
    localparam logic [3:0] ACC_RESET = 4'h0;
    localparam logic [3:0] OPERAND_RESET = 4'h0;
    localparam logic BRANCH_COND_RESET = 1'b1;

    // One instruction cycle: four states of two clocks each
    localparam int STATES_PER_CYCLE = 4;
    localparam int CLOCKS_PER_STATE = 2;
    localparam int EXEC_CYCLES = STATES_PER_CYCLE * CLOCKS_PER_STATE;
    localparam logic [3:0] EXEC_LAST = 4'(EXEC_CYCLES - 1);

    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_ADD_WITH_CARRY = 4'h1,
        OP_REVERSE_SUBTRACT_WITH_CARRY = 4'h2,
        OP_COMPARE_REVERSE = 4'h3,
        OP_ROTATE_LEFT_CARRY = 4'h4,
        OP_ROTATE_RIGHT_CARRY = 4'h5,
        OP_TEST_CARRY_TRUE = 4'h6,
        OP_TEST_CARRY_INVERTED = 4'h7,
        OP_ADD = 4'h8,
        OP_AND = 4'h9,
        OP_LOAD_ACC = 4'hA,
        OP_INPUT = 4'hB,
        OP_SET_GENERAL = 4'hC,
        OP_CLEAR_GENERAL = 4'hD,
        OP_TEST_GENERAL = 4'hE,
        OP_BRANCH = 4'hF
    } opcode_t;

    typedef enum logic [2:0] {
        FN_ADD = 3'h0,
        FN_RSUB = 3'h1,
        FN_AND = 3'h2,
        FN_PASS_B = 3'h3,
        FN_ROL = 3'h4,
        FN_ROR = 3'h5
    } alu_fn_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } ctl_state_t;

    typedef struct packed {
        logic general_flag;
        logic branch_condition_flag;
        logic zero_flag;
        logic carry_flag;
    } flags_t;

    typedef struct packed {
        logic [3:0] result;
        logic carry_out;
        logic zero_out;
    } alu_out_t;

endpackage : nibble_alu_pkg

`default_nettype wire

// ---- nibble_alu.sv ----
// Combinational 4-bit ALU: result, carry out and zero indication.
// Assumes operands and carry in are held stable by the caller.
`default_nettype none
`timescale 1ns/100ps

module nibble_alu
    import nibble_alu_pkg::*;
(
    input wire nibble_alu_pkg::alu_fn_t fn,
    input wire logic [3:0] a,
    input wire logic [3:0] b,
    input wire logic cin,
    output nibble_alu_pkg::alu_out_t alu_o
);

    logic [4:0] sum;

    always_comb begin
        sum = 5'h00;
        alu_o.carry_out = 1'b0;
        alu_o.result = 4'h0;
        unique case (fn)
            FN_ADD: begin
                sum = {1'b0, a} + {1'b0, b} + {4'h0, cin};
                alu_o.result = sum[3:0];
                alu_o.carry_out = sum[4];
            end
            FN_RSUB: begin
                // Carry out set means no borrow
                sum = {1'b0, b} + {1'b0, ~a} + {4'h0, cin};
                alu_o.result = sum[3:0];
                alu_o.carry_out = sum[4];
            end
            FN_AND: alu_o.result = a & b;
            FN_PASS_B: alu_o.result = b;
            FN_ROL: begin
                alu_o.result = {a[2:0], cin};
                alu_o.carry_out = a[3];
            end
            FN_ROR: begin
                alu_o.result = {cin, a[3:1]};
                alu_o.carry_out = a[0];
            end
            default: alu_o.result = 4'h0;
        endcase
        alu_o.zero_out = (alu_o.result == 4'h0);
    end

endmodule : nibble_alu

`default_nettype wire

// ---- flag_bank.sv ----
// The four CPU flags, loaded together at the end of an instruction.
// Assumes the caller supplies the held value for every unaffected flag.
`default_nettype none
`timescale 1ns/100ps

module flag_bank
    import nibble_alu_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic commit,
    input wire nibble_alu_pkg::flags_t flags_next,
    output nibble_alu_pkg::flags_t flags
);

    // Split storage: one driver per flop group
    logic [2:0] held_reg;
    logic branch_reg;

    // General, branch, zero, carry from the high bit down
    assign flags = {held_reg[2], branch_reg, held_reg[1:0]};

    // Carry, zero and general flags keep their value across reset,
    // so they sit in flops with no reset at all.
    always_ff @(posedge pclk) begin
        if (commit) begin
            held_reg <= {flags_next.general_flag, flags_next.zero_flag,
                flags_next.carry_flag};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            branch_reg <= BRANCH_COND_RESET;
        end else if (commit) begin
            branch_reg <= flags_next.branch_condition_flag;
        end
    end

endmodule : flag_bank

`default_nettype wire

// ---- pin_source.sv ----
// Model of the pin group that feeds the input instruction.
// Assumes the bench names the level it wants; pins move only after pclk edges.
`timescale 1ns/100ps
`default_nettype none

module pin_source (
    input wire logic pclk,
    input wire logic [3:0] level,
    output var logic [3:0] pins
);
    // Defined at time zero so the synchroniser never sees an unknown
    logic [3:0] pins_reg = 4'h0;

    assign pins = pins_reg;

    // Change just after an edge, as a board latch would
    always @(posedge pclk) begin
        pins_reg <= level;
    end
endmodule : pin_source

`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the nibble ALU flag block over APB.
// Assumes the package and design files are compiled first.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import nibble_alu_pkg::*;

    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic [DATA_W-1:0] rd;
    logic pready;
    logic pslverr;
    logic err;
    logic branch_take;
    logic [3:0] in_level;
    logic [3:0] in_port;
    int error_cnt = 0;
    int n_checks = 0;
    int take_cnt = 0;
    opcode_t ops[9] = '{OP_ADD_WITH_CARRY, OP_REVERSE_SUBTRACT_WITH_CARRY,
        OP_COMPARE_REVERSE, OP_AND, OP_LOAD_ACC, OP_ROTATE_LEFT_CARRY,
        OP_ROTATE_RIGHT_CARRY, OP_ADD, OP_NOP};
    logic [3:0] acc_exp[9] = '{4'h2, 4'h9, 4'hC, 4'h4, 4'h5, 4'h9, 4'hE, 4'h1, 4'hC};
    logic carry_exp[9] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};

    nibble_alu_flag_logic DUT (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .in_port(in_port),
        .branch_take(branch_take)
    );

    pin_source u_pins (
        .pclk(pclk),
        .level(in_level),
        .pins(in_port)
    );

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (branch_take === 1'b1) begin
            take_cnt <= take_cnt + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Request holds until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        chk(rd, exp);
    endtask : rd_chk

    // Busy accesses stall, so the next transfer waits for the end
    task automatic exec(input opcode_t op);
        apb(1'b1, INSTR_OFFSET, {28'h0, op});
    endtask : exec

    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////////

    initial begin
        #1_000_000;
        error_cnt++;
        give_verdict();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        in_level = 4'hA;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, FLAGS_OFFSET, 32'h0);
        chk({31'h0, rd[2]}, 32'h1);
        // Compare reads no flag, so it defines carry and zero first
        exec(OP_COMPARE_REVERSE);
        exec(OP_SET_GENERAL);
        // Each row starts from acc C, operand 5, carry 1
        for (int i = 0; i < 9; i++) begin
            apb(1'b1, ACC_OFFSET, 32'hC);
            apb(1'b1, OPERAND_OFFSET, 32'h5);
            exec(OP_TEST_CARRY_TRUE);
            exec(OP_TEST_CARRY_TRUE);
            exec(ops[i]);
            rd_chk(ACC_OFFSET, {28'h0, acc_exp[i]});
            rd_chk(FLAGS_OFFSET, {28'h0, 3'b110, carry_exp[i]});
            if (ops[i] == OP_COMPARE_REVERSE) begin
                rd_chk(RESULT_OFFSET, 32'h9);
            end
        end
        apb(1'b1, OPERAND_OFFSET, 32'h0);
        exec(OP_LOAD_ACC);
        rd_chk(FLAGS_OFFSET, 32'hF);
        exec(OP_INPUT);
        rd_chk(ACC_OFFSET, 32'hA);
        rd_chk(FLAGS_OFFSET, 32'hD);
        exec(OP_TEST_CARRY_TRUE);
        exec(OP_TEST_CARRY_INVERTED);
        rd_chk(FLAGS_OFFSET, 32'h8);
        exec(OP_BRANCH);
        rd_chk(STATUS_OFFSET, 32'h0);
        exec(OP_TEST_CARRY_INVERTED);
        rd_chk(FLAGS_OFFSET, 32'hC);
        exec(OP_BRANCH);
        rd_chk(STATUS_OFFSET, 32'h1);
        rd_chk(INSTR_OFFSET, 32'hF);
        chk(32'(take_cnt), 32'h1);
        exec(OP_TEST_CARRY_TRUE);
        rd_chk(FLAGS_OFFSET, 32'h9);
        exec(OP_CLEAR_GENERAL);
        exec(OP_TEST_GENERAL);
        rd_chk(FLAGS_OFFSET, 32'h1);
        exec(OP_SET_GENERAL);
        exec(OP_TEST_GENERAL);
        rd_chk(FLAGS_OFFSET, 32'hD);
        // Unmapped place answers with an error and zero data
        apb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
        // Reset in mid-run with branch flag low and carry high
        exec(OP_TEST_CARRY_INVERTED);
        exec(OP_TEST_CARRY_TRUE);
        rd_chk(FLAGS_OFFSET, 32'h9);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(FLAGS_OFFSET, 32'hD);
        exec(OP_BRANCH);
        rd_chk(STATUS_OFFSET, 32'h1);
        repeat (2) @(posedge pclk);
        chk(32'(take_cnt), 32'h2);
        give_verdict();
    end
endmodule : tb_top

`default_nettype wire
